/* verilog/sdc_pkg.sv */
// Constants and types for the skew delay serial configuration block
package sdc_pkg;

    // =========================================================================
    // Word layout and framing
    // =========================================================================
    localparam int CODE_W = 5;
    localparam int SEL_W = 2;
    localparam int CNT_W = 3;
    localparam int WORD_BITS = 8;
    localparam logic WRITE_FLAG = 1'b0;
    localparam logic [CNT_W-1:0] BIT_SEL_LO = 3'h2;
    localparam logic [CNT_W-1:0] BIT_LAST = 3'h7;
    localparam logic [CNT_W-1:0] BIT_FIRST = 3'h0;
    localparam logic [CNT_W-1:0] BIT_STEP = 3'h1;

    // =========================================================================
    // Register selects (register_select field) and reset value
    // =========================================================================
    localparam logic [SEL_W-1:0] SEL_TEST = 2'h0;
    localparam logic [SEL_W-1:0] SEL_RED = 2'h1;
    localparam logic [SEL_W-1:0] SEL_GREEN = 2'h2;
    localparam logic [SEL_W-1:0] SEL_BLUE = 2'h3;
    localparam int NREGS = 4;
    localparam logic [CODE_W-1:0] REG_RESET = 5'h00;

    // =========================================================================
    // Test register fields
    // =========================================================================
    localparam int TEST_MODE_BIT = 0;
    localparam int DAC_LSB = 1;
    localparam int DAC_MSB = 4;
    localparam int DAC_W = 4;

    // =========================================================================
    // Analog model figures
    // =========================================================================
    localparam int STEP_NS = 2;
    localparam int NS_W = 6;
    localparam int STAGES = 31;
    localparam int MV_W = 12;
    localparam logic signed [MV_W-1:0] DAC_STEP_MV = 12'sh032;
    localparam int NCH = 3;
    localparam int CH_RED = 0;
    localparam int CH_GREEN = 1;
    localparam int CH_BLUE = 2;

    // =========================================================================
    // Types
    // =========================================================================
    typedef enum logic [1:0] {
        PH_WRITE,
        PH_SELECT,
        PH_DATA,
        PH_SKIP
    } sdc_phase_t;

    typedef struct packed {
        logic frame_select_n;
        logic shift_clock;
        logic serial_in;
        logic chip_on;
    } sdc_pins_t;

    typedef struct packed {
        logic [NCH-1:0][MV_W-1:0] in_mv;
        logic [NCH-1:0][MV_W-1:0] out_mv;
    } sdc_samples_t;

    typedef struct packed {
        sdc_pins_t pin_s1;
        sdc_pins_t pin_s2;
        logic sck_prev;
        sdc_samples_t samp_s1;
        sdc_samples_t samp_s2;
        sdc_phase_t phase;
        logic [CNT_W-1:0] bit_cnt;
        logic [SEL_W-1:0] sel;
        logic [NREGS-1:0][CODE_W-1:0] regs;
        logic word_done;
        logic [NCH-1:0][STAGES-1:0] stage_en;
        logic [NCH-1:0][NS_W-1:0] delay_ns;
        logic [MV_W-1:0] dac_mv;
        logic [NCH-1:0] a_prev;
        logic [NCH-1:0] b_prev;
        logic [NCH-1:0] lead;
        logic [NCH-1:0] pulse_pos;
        logic [NCH-1:0] pulse_neg;
    } sdc_state_t;

endpackage

/* verilog/sdc_skew_delay_serial_config.sv */
// Serial configuration port, delay registers and skew detectors of the delay line
module sdc_skew_delay_serial_config (
    input wire logic i_mclk,
    input wire logic i_rst_n,
    input wire logic i_frame_select_n,
    input wire logic i_shift_clock,
    input wire logic i_serial_in,
    input wire logic i_chip_on,
    input wire logic [sdc_pkg::MV_W-1:0] i_red_in_mv,
    input wire logic [sdc_pkg::MV_W-1:0] i_green_in_mv,
    input wire logic [sdc_pkg::MV_W-1:0] i_blue_in_mv,
    input wire logic [sdc_pkg::MV_W-1:0] i_red_out_mv,
    input wire logic [sdc_pkg::MV_W-1:0] i_green_out_mv,
    input wire logic [sdc_pkg::MV_W-1:0] i_blue_out_mv,
    output logic [sdc_pkg::CODE_W-1:0] o_red_delay_code,
    output logic [sdc_pkg::CODE_W-1:0] o_green_delay_code,
    output logic [sdc_pkg::CODE_W-1:0] o_blue_delay_code,
    output logic [sdc_pkg::NS_W-1:0] o_red_delay_ns,
    output logic [sdc_pkg::NS_W-1:0] o_green_delay_ns,
    output logic [sdc_pkg::NS_W-1:0] o_blue_delay_ns,
    output logic [sdc_pkg::STAGES-1:0] o_red_stage_en,
    output logic [sdc_pkg::STAGES-1:0] o_green_stage_en,
    output logic [sdc_pkg::STAGES-1:0] o_blue_stage_en,
    output logic [sdc_pkg::CODE_W-1:0] o_test_control,
    output logic o_test_mode,
    output logic [sdc_pkg::DAC_W-1:0] o_dac_level,
    output logic [sdc_pkg::MV_W-1:0] o_dac_mv,
    output logic o_green_shows_dac,
    output logic o_word_done,
    output logic o_red_pulse_pos,
    output logic o_red_pulse_neg,
    output logic o_green_pulse_pos,
    output logic o_green_pulse_neg,
    output logic o_blue_pulse_pos,
    output logic o_blue_pulse_neg
);

    // =========================================================================
    // Helpers
    // =========================================================================
    function automatic logic [sdc_pkg::STAGES-1:0] thermo(
        input logic [sdc_pkg::CODE_W-1:0] code
    );
        logic [sdc_pkg::STAGES-1:0] t;
        t = '0;
        for (int k = 0; k < sdc_pkg::STAGES; k++) begin
            t[k] = (k < int'(code));
        end
        return t;
    endfunction

    function automatic logic [sdc_pkg::MV_W-1:0] dac_to_mv(
        input logic [sdc_pkg::DAC_W-1:0] lv
    );
        logic signed [sdc_pkg::MV_W-1:0] w;
        logic signed [sdc_pkg::MV_W-1:0] p;
        w = {{(sdc_pkg::MV_W-sdc_pkg::DAC_W){lv[sdc_pkg::DAC_W-1]}}, lv};
        p = w * sdc_pkg::DAC_STEP_MV;
        return p;
    endfunction

    function automatic logic slice(
        input logic [sdc_pkg::MV_W-1:0] sample,
        input logic [sdc_pkg::MV_W-1:0] level
    );
        return $signed(sample) > $signed(level);
    endfunction

    // =========================================================================
    // State
    // =========================================================================
    sdc_pkg::sdc_state_t s;
    sdc_pkg::sdc_state_t next_s;

    logic fall;
    logic sdi;
    logic test_mode;
    logic [sdc_pkg::NCH-1:0] det_a;
    logic [sdc_pkg::NCH-1:0] det_b;
    logic [sdc_pkg::NCH-1:0] rise_a;
    logic [sdc_pkg::NCH-1:0] rise_b;
    logic [sdc_pkg::NCH-1:0] sl_in;
    logic [sdc_pkg::NCH-1:0] sl_out;

    always_comb begin
        next_s = s;
        fall = 1'b0;
        sdi = 1'b0;
        test_mode = 1'b0;
        det_a = '0;
        det_b = '0;
        rise_a = '0;
        rise_b = '0;
        sl_in = '0;
        sl_out = '0;

        // Two-stage capture of every pin
        next_s.pin_s1.frame_select_n = i_frame_select_n;
        next_s.pin_s1.shift_clock = i_shift_clock;
        next_s.pin_s1.serial_in = i_serial_in;
        next_s.pin_s1.chip_on = i_chip_on;
        next_s.pin_s2 = s.pin_s1;
        next_s.sck_prev = s.pin_s2.shift_clock;
        next_s.samp_s1.in_mv[sdc_pkg::CH_RED] = i_red_in_mv;
        next_s.samp_s1.in_mv[sdc_pkg::CH_GREEN] = i_green_in_mv;
        next_s.samp_s1.in_mv[sdc_pkg::CH_BLUE] = i_blue_in_mv;
        next_s.samp_s1.out_mv[sdc_pkg::CH_RED] = i_red_out_mv;
        next_s.samp_s1.out_mv[sdc_pkg::CH_GREEN] = i_green_out_mv;
        next_s.samp_s1.out_mv[sdc_pkg::CH_BLUE] = i_blue_out_mv;
        next_s.samp_s2 = s.samp_s1;

        // =====================================================================
        // Serial word decoder
        // =====================================================================
        fall = s.sck_prev & ~s.pin_s2.shift_clock;
        sdi = s.pin_s2.serial_in;
        next_s.word_done = 1'b0;

        if (s.pin_s2.frame_select_n) begin
            next_s.bit_cnt = sdc_pkg::BIT_FIRST;
            next_s.phase = sdc_pkg::PH_WRITE;
        end else if (fall) begin
            next_s.bit_cnt = s.bit_cnt + sdc_pkg::BIT_STEP;
            case (s.phase)
                sdc_pkg::PH_WRITE: begin
                    // Leading bit decides whether the word writes
                    next_s.phase = (sdi == sdc_pkg::WRITE_FLAG) ?
                        sdc_pkg::PH_SELECT : sdc_pkg::PH_SKIP;
                    next_s.sel = '0;
                end
                sdc_pkg::PH_SELECT, sdc_pkg::PH_SKIP: begin
                    if (s.bit_cnt <= sdc_pkg::BIT_SEL_LO) begin
                        next_s.sel = {s.sel[0], sdi};
                        if (s.bit_cnt == sdc_pkg::BIT_SEL_LO &&
                                s.phase == sdc_pkg::PH_SELECT) begin
                            next_s.phase = sdc_pkg::PH_DATA;
                        end
                    end else if (s.bit_cnt == sdc_pkg::BIT_LAST) begin
                        next_s.phase = sdc_pkg::PH_WRITE;
                    end
                end
                sdc_pkg::PH_DATA: begin
                    // Each bit lands in the live register, MSB first
                    next_s.regs[s.sel] = {s.regs[s.sel][sdc_pkg::CODE_W-2:0], sdi};
                    if (s.bit_cnt == sdc_pkg::BIT_LAST) begin
                        next_s.phase = sdc_pkg::PH_WRITE;
                        next_s.word_done = 1'b1;
                    end
                end
                default: begin
                    next_s.phase = sdc_pkg::PH_WRITE;
                end
            endcase
        end

        // =====================================================================
        // Delay line controls
        // =====================================================================
        for (int c = 0; c < sdc_pkg::NCH; c++) begin
            // Channel c sits at select code c+1, code in low five bits
            next_s.delay_ns[c] = {1'b0, next_s.regs[c+1]} *
                sdc_pkg::NS_W'(sdc_pkg::STEP_NS);
            next_s.stage_en[c] = thermo(next_s.regs[c+1]);
        end
        next_s.dac_mv = dac_to_mv(
            next_s.regs[sdc_pkg::SEL_TEST][sdc_pkg::DAC_MSB:sdc_pkg::DAC_LSB]);
        test_mode = s.regs[sdc_pkg::SEL_TEST][sdc_pkg::TEST_MODE_BIT];

        // =====================================================================
        // Skew detectors
        // =====================================================================
        for (int c = 0; c < sdc_pkg::NCH; c++) begin
            sl_in[c] = slice(s.samp_s2.in_mv[c], s.dac_mv);
            sl_out[c] = slice(s.samp_s2.out_mv[c], s.dac_mv);
        end
        if (test_mode) begin
            // Red and blue watch their own path, green carries the DAC
            det_a[sdc_pkg::CH_RED] = sl_in[sdc_pkg::CH_RED];
            det_b[sdc_pkg::CH_RED] = sl_out[sdc_pkg::CH_RED];
            det_a[sdc_pkg::CH_BLUE] = sl_in[sdc_pkg::CH_BLUE];
            det_b[sdc_pkg::CH_BLUE] = sl_out[sdc_pkg::CH_BLUE];
        end else begin
            det_a[sdc_pkg::CH_RED] = sl_out[sdc_pkg::CH_RED];
            det_b[sdc_pkg::CH_RED] = sl_out[sdc_pkg::CH_GREEN];
            det_a[sdc_pkg::CH_GREEN] = sl_out[sdc_pkg::CH_GREEN];
            det_b[sdc_pkg::CH_GREEN] = sl_out[sdc_pkg::CH_BLUE];
            det_a[sdc_pkg::CH_BLUE] = sl_out[sdc_pkg::CH_BLUE];
            det_b[sdc_pkg::CH_BLUE] = sl_out[sdc_pkg::CH_RED];
        end
        for (int d = 0; d < sdc_pkg::NCH; d++) begin
            rise_a[d] = det_a[d] & ~s.a_prev[d];
            rise_b[d] = det_b[d] & ~s.b_prev[d];
            next_s.a_prev[d] = det_a[d];
            next_s.b_prev[d] = det_b[d];
            // Remember which edge came first; a tie counts as A leading
            // A rising onto a high B means B led, and the other way round
            if (rise_a[d]) begin
                next_s.lead[d] = rise_b[d] | ~det_b[d];
            end else if (rise_b[d]) begin
                next_s.lead[d] = det_a[d];
            end
            // No overlap, no pulse: long skew stays invisible
            next_s.pulse_pos[d] = det_a[d] & det_b[d] &
                s.pin_s2.chip_on & next_s.lead[d];
            next_s.pulse_neg[d] = det_a[d] & det_b[d] &
                s.pin_s2.chip_on & ~next_s.lead[d];
        end
    end

    // =========================================================================
    // State register
    // =========================================================================
    always_ff @(posedge i_mclk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            s <= '0;
            s.pin_s1.frame_select_n <= 1'b1;
            s.pin_s2.frame_select_n <= 1'b1;
            s.phase <= sdc_pkg::PH_WRITE;
            s.regs <= {sdc_pkg::NREGS{sdc_pkg::REG_RESET}};
        end else begin
            s <= next_s;
        end
    end

    // =========================================================================
    // Outputs
    // =========================================================================
    assign o_red_delay_code = s.regs[sdc_pkg::SEL_RED];
    assign o_green_delay_code = s.regs[sdc_pkg::SEL_GREEN];
    assign o_blue_delay_code = s.regs[sdc_pkg::SEL_BLUE];
    assign o_red_delay_ns = s.delay_ns[sdc_pkg::CH_RED];
    assign o_green_delay_ns = s.delay_ns[sdc_pkg::CH_GREEN];
    assign o_blue_delay_ns = s.delay_ns[sdc_pkg::CH_BLUE];
    assign o_red_stage_en = s.stage_en[sdc_pkg::CH_RED];
    assign o_green_stage_en = s.stage_en[sdc_pkg::CH_GREEN];
    assign o_blue_stage_en = s.stage_en[sdc_pkg::CH_BLUE];
    assign o_test_control = s.regs[sdc_pkg::SEL_TEST];
    assign o_test_mode = s.regs[sdc_pkg::SEL_TEST][sdc_pkg::TEST_MODE_BIT];
    assign o_dac_level = s.regs[sdc_pkg::SEL_TEST][sdc_pkg::DAC_MSB:sdc_pkg::DAC_LSB];
    assign o_dac_mv = s.dac_mv;
    assign o_green_shows_dac = s.regs[sdc_pkg::SEL_TEST][sdc_pkg::TEST_MODE_BIT];
    assign o_word_done = s.word_done;
    assign o_red_pulse_pos = s.pulse_pos[sdc_pkg::CH_RED];
    assign o_red_pulse_neg = s.pulse_neg[sdc_pkg::CH_RED];
    assign o_green_pulse_pos = s.pulse_pos[sdc_pkg::CH_GREEN];
    assign o_green_pulse_neg = s.pulse_neg[sdc_pkg::CH_GREEN];
    assign o_blue_pulse_pos = s.pulse_pos[sdc_pkg::CH_BLUE];
    assign o_blue_pulse_neg = s.pulse_neg[sdc_pkg::CH_BLUE];

endmodule

/* verif/sdc_host_model.sv */
// Host controller model driving the three-wire configuration port
module sdc_host_model (
    output logic o_frame_select_n,
    output logic o_shift_clock,
    output logic o_serial_in
);
    timeunit 1ns;
    timeprecision 100ps;

    // =========================================================================
    // Idle lines: clock stands high, select released
    // =========================================================================
    initial begin
        o_frame_select_n = 1'b1;
        o_shift_clock = 1'b1;
        o_serial_in = 1'b1;
    end

    // =========================================================================
    // One frame of n bits taken from w, bit 15 first, 48 ns per bit
    // =========================================================================
    task automatic send(input logic [15:0] w, input int n);
        o_frame_select_n = 1'b0;
        #24;
        for (int i = 15; i > 15 - n; i--) begin
            o_serial_in = w[i];
            #12;
            o_shift_clock = 1'b0;
            #24;
            o_shift_clock = 1'b1;
            #12;
        end
        #12;
        o_frame_select_n = 1'b1;
        // Released data line must not keep its last value
        o_serial_in = ~o_serial_in;
    endtask
endmodule

/* verif/sdc_skew_delay_serial_config_assertions.sv */
// Concurrent checks on the serial configuration block ports
module sdc_skew_delay_serial_config_assertions (
    input wire logic i_mclk,
    input wire logic i_rst_n,
    input wire logic i_frame_select_n,
    input wire logic i_chip_on,
    input wire logic [4:0] o_red_delay_code,
    input wire logic [5:0] o_red_delay_ns,
    input wire logic [4:0] o_green_delay_code,
    input wire logic [30:0] o_green_stage_en,
    input wire logic [4:0] o_test_control,
    input wire logic o_test_mode,
    input wire logic [3:0] o_dac_level,
    input wire logic [11:0] o_dac_mv,
    input wire logic o_green_shows_dac,
    input wire logic o_word_done,
    input wire logic o_red_pulse_pos,
    input wire logic o_red_pulse_neg,
    input wire logic o_green_pulse_pos,
    input wire logic o_green_pulse_neg
);
    default clocking cb @(posedge i_mclk); endclocking
    default disable iff (!i_rst_n);

    // =========================================================================
    // Assertions
    // =========================================================================
    chk_ns_twice: assert property (o_red_delay_ns == {o_red_delay_code, 1'b0})
        else $error("red delay ns not twice the code");
    chk_stage_therm: assert property (
        o_green_stage_en == (31'h7fffffff >> (5'd31 - o_green_delay_code)))
        else $error("green stage enables do not match code");
    chk_test_fields: assert property ({o_dac_level, o_test_mode} == o_test_control)
        else $error("test fields do not match register");
    chk_dac_scale: assert property ($signed(o_dac_mv) == $signed(o_dac_level) * 50)
        else $error("dac mv not level times 50");
    chk_green_dac: assert property (o_test_mode [*2] |-> o_green_shows_dac)
        else $error("green not showing dac in test mode");
    chk_green_quiet: assert property (o_test_mode [*3] |->
        !o_green_pulse_pos && !o_green_pulse_neg)
        else $error("green detector active in test mode");
    chk_idle_hold: assert property (i_frame_select_n [*5] |->
        $stable(o_red_delay_code) && $stable(o_test_control))
        else $error("register changed outside a frame");
    chk_done_single: assert property (o_word_done |=> !o_word_done [*8])
        else $error("word done too soon again");
    chk_shift_in: assert property ($changed(o_red_delay_code) |->
        (o_red_delay_code >> 1) == ($past(o_red_delay_code) & 5'h0f))
        else $error("red register not shifted one bit");
    chk_pulse_excl: assert property (!(o_red_pulse_pos && o_red_pulse_neg))
        else $error("red pulse both signs");
    chk_chip_gate: assert property (!i_chip_on [*4] |->
        !o_red_pulse_pos && !o_red_pulse_neg)
        else $error("pulse while chip off");

    cover property (o_word_done);
    cover property ($rose(o_test_mode));
    cover property (o_red_pulse_pos);
    cover property (o_red_pulse_neg);
endmodule

bind sdc_skew_delay_serial_config sdc_skew_delay_serial_config_assertions u_chk (
    .i_mclk, .i_rst_n, .i_frame_select_n, .i_chip_on, .o_red_delay_code, .o_red_delay_ns,
    .o_green_delay_code, .o_green_stage_en, .o_test_control, .o_test_mode, .o_dac_level,
    .o_dac_mv, .o_green_shows_dac, .o_word_done, .o_red_pulse_pos, .o_red_pulse_neg,
    .o_green_pulse_pos, .o_green_pulse_neg);

/* verif/sdc_skew_delay_serial_config_tb.sv */
// Self-checking bench for the skew delay serial configuration block
`define CHK(nm, exp, got) begin n_tests++; if ((got) !== (exp)) begin fails++; \
    $display("wrong value %s exp %0h got %0h", nm, exp, got); end end
module sdc_skew_delay_serial_config_tb;
    timeunit 1ns;
    timeprecision 100ps;
    localparam logic [11:0] hi_mv = 12'h064;
    localparam logic [11:0] lo_mv = 12'hf9c;
    logic i_mclk = 1'b0;
    logic i_rst_n = 1'b0;
    logic i_chip_on = 1'b1;
    logic [4:0] o_red_delay_code, o_green_delay_code, o_blue_delay_code, o_test_control;
    logic [5:0] o_red_delay_ns, o_green_delay_ns, o_blue_delay_ns;
    logic [30:0] o_red_stage_en, o_green_stage_en, o_blue_stage_en;
    logic [3:0] o_dac_level;
    logic [11:0] o_dac_mv, i_red_in_mv, i_green_in_mv, i_blue_in_mv;
    logic [11:0] i_red_out_mv, i_green_out_mv, i_blue_out_mv;
    logic o_test_mode, o_green_shows_dac, o_word_done, o_red_pulse_pos, o_red_pulse_neg;
    logic o_green_pulse_pos, o_green_pulse_neg, o_blue_pulse_pos, o_blue_pulse_neg;
    wire logic i_frame_select_n, i_shift_clock, i_serial_in;
    int fails = 0;
    int n_tests = 0;
    int n_done = 0;

    sdc_skew_delay_serial_config u_dut (.*);
    sdc_host_model u_host (.o_frame_select_n(i_frame_select_n),
        .o_shift_clock(i_shift_clock), .o_serial_in(i_serial_in));

    always #2 i_mclk = ~i_mclk;
    always @(negedge i_mclk) if (o_word_done === 1'b1) n_done++;

    // =========================================================================
    // Helpers
    // =========================================================================
    task automatic word(input logic [15:0] w, input int n);
        @(negedge i_mclk);
        u_host.send(w, n);
        repeat (8) @(negedge i_mclk);
    endtask

    // Levels {r_in, g_in, b_in, r_out, g_out, b_out}, then wait
    task automatic drive(input logic [5:0] h, input int n);
        i_red_in_mv = h[5] ? hi_mv : lo_mv;
        i_green_in_mv = h[4] ? hi_mv : lo_mv;
        i_blue_in_mv = h[3] ? hi_mv : lo_mv;
        i_red_out_mv = h[2] ? hi_mv : lo_mv;
        i_green_out_mv = h[1] ? hi_mv : lo_mv;
        i_blue_out_mv = h[0] ? hi_mv : lo_mv;
        repeat (n) @(negedge i_mclk);
    endtask

    // =========================================================================
    // Scenarios
    // =========================================================================
    task automatic t_reset;
        i_rst_n = 1'b0;
        repeat (5) @(negedge i_mclk);
        `CHK("red", 5'h00, o_red_delay_code)
        `CHK("green", 5'h00, o_green_delay_code)
        `CHK("blue", 5'h00, o_blue_delay_code)
        `CHK("test", 5'h00, o_test_control)
        i_rst_n = 1'b1;
        repeat (3) @(negedge i_mclk);
    endtask

    task automatic t_write;
        int d0;
        d0 = n_done;
        word(16'h3600, 8);
        word(16'h5f00, 8);
        word(16'h6100, 8);
        word(16'h1100, 8);
        `CHK("red", 5'h16, o_red_delay_code)
        `CHK("red ns", 6'h2c, o_red_delay_ns)
        `CHK("red stages", 31'h003fffff, o_red_stage_en)
        `CHK("green ns", 6'h3e, o_green_delay_ns)
        `CHK("green stages", 31'h7fffffff, o_green_stage_en)
        `CHK("blue", 5'h01, o_blue_delay_code)
        `CHK("blue stages", 31'h00000001, o_blue_stage_en)
        `CHK("mode", 1'b1, o_test_mode)
        `CHK("dac", 12'he70, o_dac_mv)
        `CHK("green dac", 1'b1, o_green_shows_dac)
        `CHK("done", 4, n_done - d0)
    endtask

    task automatic t_stream;
        word(16'h9f2a, 16);
        `CHK("test kept", 5'h11, o_test_control)
        `CHK("red", 5'h0a, o_red_delay_code)
        word(16'h2b63, 16);
        `CHK("red", 5'h0b, o_red_delay_code)
        `CHK("blue", 5'h03, o_blue_delay_code)
    endtask

    task automatic t_short;
        word(16'h3000, 5);
        `CHK("red mix", 5'h0e, o_red_delay_code)
        word(16'h4400, 8);
        `CHK("green", 5'h04, o_green_delay_code)
    endtask

    task automatic t_detect;
        word(16'h0000, 8);
        drive(6'b000100, 5);
        drive(6'b000110, 4);
        `CHK("red pos", 1'b1, o_red_pulse_pos)
        `CHK("red neg", 1'b0, o_red_pulse_neg)
        drive(6'b000010, 5);
        drive(6'b000110, 4);
        `CHK("red neg", 1'b1, o_red_pulse_neg)
        i_chip_on = 1'b0;
        drive(6'b000110, 5);
        `CHK("red off", 1'b0, o_red_pulse_neg)
        i_chip_on = 1'b1;
        drive(6'b000000, 6);
        word(16'h0e00, 8);
        drive(6'b000110, 6);
        `CHK("below slice", 1'b0, o_red_pulse_pos)
        drive(6'b000000, 4);
        word(16'h0100, 8);
        drive(6'b100000, 3);
        drive(6'b100100, 4);
        `CHK("self delay", 1'b1, o_red_pulse_pos)
        drive(6'b000000, 4);
    endtask

    task automatic summarize;
        $display("checks %0d mismatches %0d", n_tests, fails);
        if (fails == 0 && n_tests > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask

    initial begin
        drive(6'b000000, 0);
        t_reset();
        t_write();
        t_stream();
        t_short();
        t_detect();
        t_reset();
        summarize();
    end

    initial begin
        #100000;
        fails++;
        summarize();
    end
endmodule
